/* design/cst_status_regs.sv */
// Functional notes
// - Five-bit data compare count, above 10001 invalid
// - Read-only matched filter index, 0 to 15
// - Module interrupt codes 1000000 to 1000100
// - Codes 0 to 15 name interrupting buffer
// - Three-bit buffer area size, 111 reserved
// - Writable five-bit FIFO first buffer
// - Read-only six-bit FIFO write pointer
// - Read-only six-bit FIFO read pointer
// - Six error-state bits at 13 to 8
// - Error flag raised from error-state bits
// - Seven sticky flags, software clears only
// - Seven enables at matching flag positions
// - Transmit and receive error counters, read-only
// - Jump width codes give 1 to 4 quanta
// - Quantum is 2 times (prescaler+1) clocks
// - Config entry clears counters, keeps flags
// - Disabled module still sets wake-up flag
`timescale 1ns/1ps
`default_nettype none
module cst_status_regs
   import cst_pkg::*;
(
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             srst,
   // AHB-Lite slave
   input  wire logic             hsel,
   input  wire logic [7:0]       haddr,
   input  wire logic [1:0]       htrans,
   input  wire logic             hwrite,
   input  wire logic [2:0]       hsize,
   input  wire logic [31:0]      hwdata,
   input  wire logic             hready,
   output logic                  hreadyout,
   output logic                  hresp,
   output logic [31:0]           hrdata,
   // Frame engine side
   input  wire cst_event_type    evt,
   input  wire cst_errstate_type errst,
   input  wire logic [4:0]       dcmp_in,
   input  wire logic [5:0]       wptr_in,
   input  wire logic [5:0]       rptr_in,
   output cst_cfg_type           cfg,
   output cst_mode_type          mode,
   output logic                  tq_pulse,
   output logic                  dcmp_invalid,
   // Interrupt
   output logic                  irq
);
   // Bus address phase capture
   logic       wr_pend_ff;
   logic       rd_pend_ff;
   logic [7:0] addr_ff;
   wire        acc_ok = hsel && hready && htrans[1];

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         wr_pend_ff <= 1'b0;
         rd_pend_ff <= 1'b0;
         addr_ff    <= 8'h00;
      end else begin
         wr_pend_ff <= acc_ok && hwrite;
         rd_pend_ff <= acc_ok && !hwrite;
         if (acc_ok) addr_ff <= haddr;
      end
   end

   // Zero-wait slave, always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   wire wr_flags = wr_pend_ff && (addr_ff == ADDR_INT_FLAGS);
   wire wr_ena   = wr_pend_ff && (addr_ff == ADDR_INT_ENABLES);
   wire wr_fctl  = wr_pend_ff && (addr_ff == ADDR_FIFO_CTRL);
   wire wr_tim   = wr_pend_ff && (addr_ff == ADDR_BIT_TIMING);
   wire wr_mode  = wr_pend_ff && (addr_ff == ADDR_MODE_CTRL);

   // Mode register; config and timing edits only take in config mode
   cst_mode_type mode_ff;
   cst_mode_type nxt_mode;
   assign nxt_mode = (hwdata[1:0] == 2'b01) ? CST_MODE_CONFIG :
                     (hwdata[1:0] == 2'b11) ? CST_MODE_DISABLE :
                     CST_MODE_NORMAL;
   always_ff @(posedge clk_sys) begin
      if (srst) mode_ff <= CST_MODE_CONFIG;
      else if (wr_mode) mode_ff <= nxt_mode;
   end
   assign mode = mode_ff;
   wire in_cfg    = (mode_ff == CST_MODE_CONFIG);
   wire cfg_entry = wr_mode && (nxt_mode == CST_MODE_CONFIG) && !in_cfg;

   // FIFO control and bit timing settings
   logic [2:0] babs_ff;
   logic [4:0] fsa_ff;
   logic [7:0] timing_ff;
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         babs_ff   <= BABS_RST;
         fsa_ff    <= FCTRL_LO_RST[4:0];
         timing_ff <= TIMING_RST;
      end else begin
         if (wr_fctl && in_cfg) begin
            babs_ff <= hwdata[BABS_LSB +: 3];
            fsa_ff  <= hwdata[4:0];
         end
         if (wr_tim && in_cfg) timing_ff <= hwdata[7:0];
      end
   end

   // Buffer count decode; reserved code reads back but gives 32
   logic [5:0] buf_cnt;
   always_comb begin
      case (babs_ff)
         3'h0:    buf_cnt = 6'd4;
         3'h1:    buf_cnt = 6'd6;
         3'h2:    buf_cnt = 6'd8;
         3'h3:    buf_cnt = 6'd12;
         3'h4:    buf_cnt = 6'd16;
         3'h5:    buf_cnt = 6'd24;
         default: buf_cnt = 6'd32;
      endcase
   end

   assign cfg.data_compare_bits = dcmp_in;
   assign cfg.buffer_area_size  = babs_ff;
   assign cfg.buffer_count      = buf_cnt;
   assign cfg.fifo_first_buffer = fsa_ff;
   assign cfg.resync_jump_width = timing_ff[SJW_LSB +: 2];
   assign cfg.sjw_quanta = {1'b0, timing_ff[SJW_LSB +: 2]} + 3'h1;
   assign cfg.quantum_prescaler = timing_ff[5:0];
   assign dcmp_invalid = (dcmp_in > DCMP_MAX);

   // Time quantum divider runs in normal mode only
   cst_quantum_gen u_tq (
      .clk_sys           (clk_sys),
      .srst              (srst),
      .run               (!in_cfg && (mode_ff != CST_MODE_DISABLE)),
      .quantum_prescaler (timing_ff[5:0]),
      .tq_pulse          (tq_pulse)
   );

   // Error state mirrors and counters
   logic [5:0] errst_ff;
   logic [7:0] txec_ff;
   logic [7:0] rxec_ff;
   logic [4:0] filt_ff;
   logic [3:0] buf_ff;
   logic       buf_vld_ff;
   logic [5:0] wptr_ff;
   logic [5:0] rptr_ff;
   wire  any_warn = errst.tx_error_warning || errst.rx_error_warning;
   wire  [5:0] nxt_errst = {errst.tx_bus_off, errst.tx_error_passive,
                            errst.rx_error_passive, errst.tx_error_warning,
                            errst.rx_error_warning, any_warn};
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         errst_ff <= 6'h00;
         txec_ff  <= 8'h00;
         rxec_ff  <= 8'h00;
      end else begin
         errst_ff <= nxt_errst;
         if (cfg_entry || in_cfg) begin
            txec_ff <= 8'h00;
            rxec_ff <= 8'h00;
         end else if (errst.cnt_valid && mode_ff == CST_MODE_NORMAL) begin
            txec_ff <= errst.tx_count;
            rxec_ff <= errst.rx_count;
         end
      end
   end

   // Filter hit, buffer number and FIFO pointers
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         filt_ff    <= 5'h00;
         buf_ff     <= 4'h0;
         buf_vld_ff <= 1'b0;
         wptr_ff    <= PTR_RST;
         rptr_ff    <= PTR_RST;
      end else begin
         if (evt.filt_valid && evt.filt_idx <= FILT_MAX)
            filt_ff <= evt.filt_idx;
         if (evt.buf_valid) begin
            buf_ff     <= evt.buf_num;
            buf_vld_ff <= 1'b1;
         end else if (wr_flags && hwdata[0] && hwdata[1]) begin
            buf_vld_ff <= 1'b0;
         end
         wptr_ff <= {1'b0, wptr_in[4:0]};
         rptr_ff <= {1'b0, rptr_in[4:0]};
      end
   end

   // Sticky flags: hardware set wins over software clear
   logic [7:0] flags_ff;
   logic [7:0] ena_ff;
   logic [7:0] set_vec;
   logic       err_rise;
   assign err_rise = |(nxt_errst & ~errst_ff);
   assign set_vec = {evt.invalid_msg && (mode_ff != CST_MODE_DISABLE),
                     evt.wakeup,
                     err_rise && (mode_ff != CST_MODE_DISABLE),
                     1'b0,
                     evt.fifo_full, evt.rx_ovf, evt.rx_buf, evt.tx_buf};
   wire [7:0] clr_vec = wr_flags ? hwdata[7:0] : 8'h00;
   wire [7:0] nxt_flags = ((flags_ff & ~clr_vec) | set_vec) & FLAG_MASK;
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         flags_ff <= FLAGS_RST;
         ena_ff   <= FLAGS_RST;
      end else begin
         flags_ff <= nxt_flags;
         if (wr_ena) ena_ff <= hwdata[7:0] & FLAG_MASK;
      end
   end

   // One level interrupt for any enabled flag
   wire [7:0] pend = flags_ff & ena_ff;
   assign irq = |pend;

   // Priority: error, wake-up, overflow, almost full, buffer; invalid gives no code
   logic [6:0] code;
   always_comb begin
      if (flags_ff[FLAG_ERR])      code = CODE_ERROR;
      else if (flags_ff[6])        code = CODE_WAKEUP;
      else if (flags_ff[2])        code = CODE_RX_OVF;
      else if (flags_ff[3])        code = CODE_FIFO_FULL;
      else if ((flags_ff[1] || flags_ff[0]) && buf_vld_ff)
         code = {3'h0, buf_ff};
      else                         code = CODE_NONE;
   end

   // Read mux; unmapped addresses read zero
   logic [15:0] rd_word;
   always_comb begin
      case (addr_ff)
         ADDR_DATA_COMPARE: rd_word = {11'h000, dcmp_in};
         ADDR_INT_CODE:     rd_word = {3'h0, filt_ff, 1'b0, code};
         ADDR_FIFO_CTRL:    rd_word = {babs_ff, 8'h00, fsa_ff};
         ADDR_FIFO_STAT:    rd_word = {2'h0, wptr_ff, 2'h0, rptr_ff};
         ADDR_INT_FLAGS:    rd_word = {2'h0, errst_ff, flags_ff};
         ADDR_INT_ENABLES:  rd_word = {8'h00, ena_ff};
         ADDR_ERR_COUNTS:   rd_word = {txec_ff, rxec_ff};
         ADDR_BIT_TIMING:   rd_word = {8'h00, timing_ff};
         ADDR_MODE_CTRL:    rd_word = {14'h0000, mode_ff};
         default:           rd_word = 16'h0000;
      endcase
   end
   assign hrdata = rd_pend_ff ? {16'h0000, rd_word} : 32'h0000_0000;

   // Checks
   chk_flag_set_wins: assert property (@(posedge clk_sys) disable iff (srst)
      evt.rx_buf |=> flags_ff[1]) else $error("flag set lost");
   chk_flag_no_swset: assert property (@(posedge clk_sys) disable iff (srst)
      (!flags_ff[0] && !evt.tx_buf) |=> !flags_ff[0])
      else $error("flag set without event");
   chk_irq_level: assert property (@(posedge clk_sys) disable iff (srst)
      irq == |(flags_ff & ena_ff)) else $error("irq mismatch");
   chk_err_flag_src: assert property (@(posedge clk_sys) disable iff (srst)
      ($rose(errst_ff[5]) && $past(mode_ff) != CST_MODE_DISABLE)
      |-> flags_ff[FLAG_ERR]) else $error("error flag missed");
   chk_cfg_clears_cnt: assert property (@(posedge clk_sys) disable iff (srst)
      cfg_entry |=> (txec_ff == 8'h00 && rxec_ff == 8'h00))
      else $error("counters kept on config entry");
   chk_cfg_keeps_flags: assert property (@(posedge clk_sys) disable iff (srst)
      (cfg_entry && !wr_flags) |=> ((flags_ff & $past(flags_ff))
      == $past(flags_ff))) else $error("flags lost on config");
   chk_wake_disabled: assert property (@(posedge clk_sys) disable iff (srst)
      (mode_ff == CST_MODE_DISABLE && evt.wakeup) |=> flags_ff[6])
      else $error("wake-up missed while disabled");
   chk_code_priority: assert property (@(posedge clk_sys) disable iff (srst)
      flags_ff[FLAG_ERR] |-> code == CODE_ERROR)
      else $error("priority wrong");
   chk_code_none: assert property (@(posedge clk_sys) disable iff (srst)
      (flags_ff[6:2] == 5'h00 && !(|flags_ff[1:0])) |-> code == CODE_NONE)
      else $error("code not idle");
   chk_sjw_range: assert property (@(posedge clk_sys) disable iff (srst)
      cfg.sjw_quanta == timing_ff[7:6] + 3'h1)
      else $error("jump width decode");
   chk_ptr_range: assert property (@(posedge clk_sys) disable iff (srst)
      !wptr_ff[5] && !rptr_ff[5]) else $error("pointer out of range");

   cov_irq: cover property (@(posedge clk_sys) disable iff (srst) $rose(irq));
   cov_cfg: cover property (@(posedge clk_sys) disable iff (srst) cfg_entry);
   cov_clr: cover property (@(posedge clk_sys) disable iff (srst)
      $fell(flags_ff[1]));
   cov_buf: cover property (@(posedge clk_sys) disable iff (srst)
      code == 7'h0f);
endmodule : cst_status_regs
`default_nettype wire

/* design/cst_pkg.sv */
`default_nettype none
package cst_pkg;
   // Register byte addresses on the AHB-Lite bus
   localparam logic [7:0] ADDR_DATA_COMPARE = 8'h00;
   localparam logic [7:0] ADDR_INT_CODE     = 8'h04;
   localparam logic [7:0] ADDR_FIFO_CTRL    = 8'h08;
   localparam logic [7:0] ADDR_FIFO_STAT    = 8'h0c;
   localparam logic [7:0] ADDR_INT_FLAGS    = 8'h10;
   localparam logic [7:0] ADDR_INT_ENABLES  = 8'h14;
   localparam logic [7:0] ADDR_ERR_COUNTS   = 8'h18;
   localparam logic [7:0] ADDR_BIT_TIMING   = 8'h1c;
   localparam logic [7:0] ADDR_MODE_CTRL    = 8'h20;

   // Field positions
   localparam int FILT_LSB   = 8;
   localparam int BABS_LSB   = 13;
   localparam int WPTR_LSB   = 8;
   localparam int ERRST_LSB  = 8;
   localparam int TXEC_LSB   = 8;
   localparam int SJW_LSB    = 6;
   localparam int FLAG_ERR   = 5;

   // Reset values and limits
   localparam logic [4:0] DCMP_MAX       = 5'h11;
   localparam logic [4:0] FILT_MAX       = 5'h0f;
   localparam logic [7:0] FLAGS_RST      = 8'h00;
   localparam logic [7:0] FLAG_MASK      = 8'hef;
   localparam logic [7:0] TIMING_RST     = 8'h00;
   localparam logic [7:0] FCTRL_LO_RST   = 8'h00;
   localparam logic [2:0] BABS_RST       = 3'h0;
   localparam logic [2:0] BABS_RSVD      = 3'h7;
   localparam logic [5:0] PTR_RST        = 6'h00;

   // Interrupt source codes
   localparam logic [6:0] CODE_FIFO_FULL = 7'h44;
   localparam logic [6:0] CODE_RX_OVF    = 7'h43;
   localparam logic [6:0] CODE_WAKEUP    = 7'h42;
   localparam logic [6:0] CODE_ERROR     = 7'h41;
   localparam logic [6:0] CODE_NONE      = 7'h40;
   localparam logic [6:0] CODE_INVALID   = 7'h45;

   // Mode of the module, as driven by the mode control register
   typedef enum logic [1:0] {
      CST_MODE_NORMAL  = 2'b00,
      CST_MODE_CONFIG  = 2'b01,
      CST_MODE_DISABLE = 2'b11
   } cst_mode_type;

   // Events from the frame engine
   typedef struct packed {
      logic       invalid_msg;
      logic       wakeup;
      logic       fifo_full;
      logic       rx_ovf;
      logic       rx_buf;
      logic       tx_buf;
      logic       buf_valid;
      logic [3:0] buf_num;
      logic       filt_valid;
      logic [4:0] filt_idx;
   } cst_event_type;

   // Error state and counters from the frame engine
   typedef struct packed {
      logic       tx_bus_off;
      logic       tx_error_passive;
      logic       rx_error_passive;
      logic       tx_error_warning;
      logic       rx_error_warning;
      logic       cnt_valid;
      logic [7:0] tx_count;
      logic [7:0] rx_count;
   } cst_errstate_type;

   // Settings handed to the frame engine
   typedef struct packed {
      logic [4:0] data_compare_bits;
      logic [2:0] buffer_area_size;
      logic [5:0] buffer_count;
      logic [4:0] fifo_first_buffer;
      logic [1:0] resync_jump_width;
      logic [2:0] sjw_quanta;
      logic [5:0] quantum_prescaler;
   } cst_cfg_type;
endpackage : cst_pkg
`default_nettype wire

/* design/cst_quantum_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module cst_quantum_gen
   import cst_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       srst,
   // Control
   input  wire logic       run,
   input  wire logic [5:0] quantum_prescaler,
   // Quantum enable pulse
   output logic            tq_pulse
);
   // Half-period counter counts 0..prescaler, toggle phase doubles it
   logic [5:0] cnt_ff;
   logic       phase_ff;
   wire        half_done = (cnt_ff == quantum_prescaler);

   // Quantum lasts 2*(prescaler+1) clocks
   always_ff @(posedge clk_sys) begin
      if (srst || !run) begin
         cnt_ff   <= 6'h00;
         phase_ff <= 1'b0;
      end else if (half_done) begin
         cnt_ff   <= 6'h00;
         phase_ff <= ~phase_ff;
      end else begin
         cnt_ff   <= cnt_ff + 6'h01;
      end
   end

   assign tq_pulse = run && half_done && phase_ff;

   // Cycles since the last pulse, or since the divider started
   int gap_cnt;
   always_ff @(posedge clk_sys) begin
      if (srst || !run || tq_pulse) gap_cnt <= 0;
      else gap_cnt <= gap_cnt + 1;
   end
   chk_quantum_len: assert property (@(posedge clk_sys) disable iff (srst)
      tq_pulse |-> (gap_cnt == 2 * (int'(quantum_prescaler) + 1) - 1))
      else $error("quantum length wrong");
   chk_quantum_gap: assert property (@(posedge clk_sys) disable iff (srst)
      tq_pulse |=> !tq_pulse) else $error("quantum pulses adjacent");
endmodule : cst_quantum_gen
`default_nettype wire

/* testbench/cst_engine_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cst_engine_model
   import cst_pkg::*;
(
   // Clock and quantum
   input  wire logic        clk_sys,
   input  wire logic        tq_pulse,
   // Engine outputs
   output cst_event_type    evt,
   output cst_errstate_type errst,
   output logic [4:0]       dcmp_in,
   output logic [5:0]       wptr_in,
   output logic [5:0]       rptr_in
);
   int gap_cnt;
   int tq_gap;

   initial begin
      evt     = '0;
      errst   = '0;
      dcmp_in = 5'h00;
      wptr_in = 6'h00;
      rptr_in = 6'h00;
      gap_cnt = 0;
      tq_gap  = 0;
   end

   // Events last one cycle only, as the real engine strobes them
   task fire(input cst_event_type e);
      evt <= e;
      @(posedge clk_sys);
      evt <= '0;
   endtask : fire

   // Error state is a level that the engine holds
   task set_err(input cst_errstate_type e);
      errst <= e;
   endtask : set_err

   task set_lv(input logic [4:0] d, input logic [5:0] w, input logic [5:0] r);
      dcmp_in <= d;
      wptr_in <= w;
      rptr_in <= r;
   endtask : set_lv

   // Distance between quantum pulses; first value after start also counts the stopped time
   always @(posedge clk_sys) begin
      if (tq_pulse) begin
         tq_gap  <= gap_cnt + 1;
         gap_cnt <= 0;
      end else begin
         gap_cnt <= gap_cnt + 1;
      end
   end
endmodule : cst_engine_model
`default_nettype wire

/* testbench/cst_status_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module cst_status_regs_tb import cst_pkg::*;;
   logic             clk_sys, srst, hsel, hwrite;
   logic [7:0]       haddr;
   logic [1:0]       htrans;
   logic [2:0]       hsize;
   logic [31:0]      hwdata, hrdata, rd;
   logic             hreadyout, hresp, tq_pulse, dcmp_invalid, irq;
   cst_event_type    evt, e;
   cst_errstate_type errst, es;
   logic [4:0]       dcmp_in, v;
   logic [5:0]       wptr_in, rptr_in;
   cst_cfg_type      cfg;
   cst_mode_type     mode;
   int miscompares = 0;
   int comparisons = 0;
   int cycles = 0;
   int i, b;
   int sizes [7] = '{4, 6, 8, 12, 16, 24, 32};
   int pres [3] = '{0, 5, 63};
   int bits [6] = '{7, 6, 3, 2, 1, 0};
   logic [6:0] codes [6] = '{7'h40, 7'h42, 7'h44, 7'h43, 7'h0f, 7'h00};
   logic [4:0] dvals [4] = '{5'h00, 5'h11, 5'h12, 5'h1f};

   cst_status_regs u_cst_status_regs (.clk_sys(clk_sys), .srst(srst),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .evt(evt),
      .errst(errst), .dcmp_in(dcmp_in), .wptr_in(wptr_in),
      .rptr_in(rptr_in), .cfg(cfg), .mode(mode), .tq_pulse(tq_pulse),
      .dcmp_invalid(dcmp_invalid), .irq(irq));

   cst_engine_model u_cst_engine_model (.clk_sys(clk_sys),
      .tq_pulse(tq_pulse), .evt(evt), .errst(errst), .dcmp_in(dcmp_in),
      .wptr_in(wptr_in), .rptr_in(rptr_in));

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   task end_of_test();
      if (miscompares == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_of_test

   // Whole run needs a little over a thousand cycles
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         end_of_test();
      end
   end

   task chk(input string n, input logic [31:0] ex, input logic [31:0] got);
      comparisons++;
      if (got !== ex) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, ex, got);
      end
   endtask : chk

   // One single AHB-Lite word transfer; data taken at the data-phase edge
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      hsize <= 3'h2;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus

   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task rdc(input logic [7:0] a, input logic [31:0] ex, input string n);
      bus(1'b0, a, 32'h0);
      chk(n, ex, rd);
   endtask : rdc

   initial begin
      srst = 1'b1;
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      repeat (3) @(posedge clk_sys);
      srst <= 1'b0;
      // Reset values, mode starts in config, 0x24 is unmapped
      for (i = 0; i < 10; i++) begin
         rdc(8'(i * 4), (i == 1) ? 32'h40 : (i == 8) ? 32'h1 : 32'h0, "rst");
      end
      chk("hresp", 32'h0, {31'h0, hresp});
      chk("hready", 32'h1, {31'h0, hreadyout});
      // Buffer area size codes, read back settles cfg before checking
      for (i = 0; i < 7; i++) begin
         wr(ADDR_FIFO_CTRL, 32'(i << 13) | 32'h1f);
         rdc(ADDR_FIFO_CTRL, 32'(i << 13) | 32'h1f, "fctrl");
         chk("bufcnt", 32'(sizes[i]), 32'(cfg.buffer_count));
         chk("babs", 32'(i), 32'(cfg.buffer_area_size));
      end
      chk("fsa", 32'h1f, 32'(cfg.fifo_first_buffer));
      for (i = 0; i < 4; i++) begin
         wr(ADDR_BIT_TIMING, 32'(i << 6));
         rdc(ADDR_BIT_TIMING, 32'(i << 6), "timing");
         chk("sjw", 32'(i + 1), 32'(cfg.sjw_quanta));
         chk("sjwc", 32'(i), 32'(cfg.resync_jump_width));
      end
      // Divider only runs outside config, so toggle mode per setting
      for (i = 0; i < 3; i++) begin
         wr(ADDR_BIT_TIMING, 32'(pres[i]));
         wr(ADDR_MODE_CTRL, 32'h0);
         repeat (300) @(posedge clk_sys);
         chk("mode", 32'h0, 32'(mode));
         chk("brp", 32'(pres[i]), 32'(cfg.quantum_prescaler));
         chk("tq", 32'(2 * (pres[i] + 1)), 32'(u_cst_engine_model.tq_gap));
         wr(ADDR_MODE_CTRL, 32'h1);
      end
      // Locked and read-only registers ignore writes
      wr(ADDR_MODE_CTRL, 32'h0);
      wr(ADDR_FIFO_CTRL, 32'h0);
      wr(ADDR_BIT_TIMING, 32'h0);
      wr(ADDR_ERR_COUNTS, 32'hffff);
      rdc(ADDR_FIFO_CTRL, 32'hc01f, "flock");
      rdc(ADDR_BIT_TIMING, 32'h3f, "tlock");
      rdc(ADDR_ERR_COUNTS, 32'h0, "ecro");
      for (i = 0; i < 4; i++) begin
         v = dvals[i];
         u_cst_engine_model.set_lv(v, {1'b0, v}, 6'h1f - {1'b0, v});
         rdc(ADDR_DATA_COMPARE, 32'(v), "dcmp");
         chk("dinv", 32'(v > 5'h11), 32'(dcmp_invalid));
         chk("dcfg", 32'(v), 32'(cfg.data_compare_bits));
         rdc(ADDR_FIFO_STAT, {19'h0, v, 3'h0, 5'h1f - v},
             "ptrs");
      end
      // Filter hit latch; index 16 is reserved and dropped
      e = '0;
      e.filt_valid = 1'b1;
      e.filt_idx = 5'h0f;
      u_cst_engine_model.fire(e);
      rdc(ADDR_INT_CODE, 32'h0f40, "filt");
      e.filt_idx = 5'h10;
      u_cst_engine_model.fire(e);
      rdc(ADDR_INT_CODE, 32'h0f40, "filt16");
      // Each event: flag, code, masking, clear-only behaviour
      for (i = 0; i < 6; i++) begin
         b = bits[i];
         e = '0;
         e.invalid_msg = (b == 7);
         e.wakeup = (b == 6);
         e.fifo_full = (b == 3);
         e.rx_ovf = (b == 2);
         e.rx_buf = (b == 1);
         e.tx_buf = (b == 0);
         e.buf_valid = (b < 2);
         e.buf_num = (b == 1) ? 4'hf : 4'h0;
         u_cst_engine_model.fire(e);
         rdc(ADDR_INT_FLAGS, 32'(1 << b), "flag");
         rdc(ADDR_INT_CODE, {24'h0f, 1'b0, codes[i]}, "code");
         chk("irqm", 32'h0, 32'(irq));
         wr(ADDR_INT_ENABLES, 32'(1 << b));
         rdc(ADDR_INT_ENABLES, 32'(1 << b), "en");
         chk("irq", 32'h1, 32'(irq));
         wr(ADDR_INT_FLAGS, 32'h0);
         rdc(ADDR_INT_FLAGS, 32'(1 << b), "keep");
         wr(ADDR_INT_FLAGS, 32'(1 << b));
         rdc(ADDR_INT_FLAGS, 32'h0, "clr");
         chk("irqc", 32'h0, 32'(irq));
      end
      // Error state beats wake-up in the code
      wr(ADDR_INT_ENABLES, 32'h20);
      es = '0;
      es.tx_error_warning = 1'b1;
      es.cnt_valid = 1'b1;
      es.tx_count = 8'h80;
      es.rx_count = 8'h7f;
      u_cst_engine_model.set_err(es);
      e = '0;
      e.wakeup = 1'b1;
      u_cst_engine_model.fire(e);
      rdc(ADDR_INT_FLAGS, 32'h0560, "errf");
      rdc(ADDR_INT_CODE, 32'h0f41, "prio");
      chk("irqe", 32'h1, 32'(irq));
      rdc(ADDR_ERR_COUNTS, 32'h807f, "cnt");
      es.cnt_valid = 1'b0;
      u_cst_engine_model.set_err(es);
      // Disabled module still sees bus activity and keeps counts
      wr(ADDR_MODE_CTRL, 32'h3);
      wr(ADDR_INT_FLAGS, 32'h40);
      u_cst_engine_model.fire(e);
      rdc(ADDR_INT_FLAGS, 32'h0560, "wake");
      rdc(ADDR_ERR_COUNTS, 32'h807f, "dcnt");
      wr(ADDR_MODE_CTRL, 32'h1);
      rdc(ADDR_ERR_COUNTS, 32'h0, "ccnt");
      chk("cmode", 32'h1, 32'(mode));
      rdc(ADDR_INT_FLAGS, 32'h0560, "cflg");
      es.tx_bus_off = 1'b1;
      es.tx_error_passive = 1'b1;
      es.rx_error_passive = 1'b1;
      es.rx_error_warning = 1'b1;
      u_cst_engine_model.set_err(es);
      rdc(ADDR_INT_FLAGS, 32'h3f60, "allst");
      end_of_test();
   end
endmodule : cst_status_regs_tb
`default_nettype wire
